// *** logic/video_link_tx_defs.vh ***
// constants for the video link transmitter control block
// assumes one 100 MHz system clock that is also the pixel clock
//
// Notes on behaviour
// RQ1 - host keeps start delay plus pixel count below 2047.
// RQ2 - host may count the delay from the inactive line sync edge.
// RQ3 - pin mode: sense output high with powered receiver, else low.
// RQ4 - sub-address 0B is read only; bus writes to it are ignored.
// RQ5 - sub-address 08 holds be after reset.
// RQ6 - top blanking control bit always goes out as zero.
// RQ7 - pin mode ignores the old third control pin.
// RQ8 - bus mode: bit 3 of 0A reads back but is never encoded.
// RQ9 - pin mode without deskew: two pins give the user bits.
// RQ10 - while window low, syncs and control bits ride the pixel channels.
// RQ11 - bits 2 and 1 of 0A hold user bits sent in blanking.
// RQ12 - registers are 8-bit locations by sub-address on the serial bus.
`ifndef VIDEO_LINK_TX_DEFS_VH
`define VIDEO_LINK_TX_DEFS_VH

// sub-addresses
`define SA_CONFIG_DEFAULT   8'h08
`define SA_USER_CONTROL     8'h0a
`define SA_STATUS           8'h0b
`define SA_DELAY_LO         8'h32
`define SA_DELAY_HI         8'h33
`define SA_COUNT_LO         8'h34
`define SA_COUNT_HI         8'h35

// reset values
`define RST_CONFIG_DEFAULT  8'hbe
`define RST_USER_CONTROL    3'h0

// field positions
`define UCB_USER_HI         2
`define UCB_USER_LO         1
`define UCB_RESERVED        3
`define DHI_GEN_ENABLE      6
`define DHI_INACTIVE_REF    5
`define STS_RX_PRESENT      0
`define STS_BUS_MODE        1
`define STS_FIFO_FULL       2

// default serial bus device address (7 bit)
`define BUS_DEV_ADDR        7'h38

`endif

// *** logic/sample_fifo.v ***
// small synchronous fifo with valid/ready on both sides
// assumes both sides run on the same clock and reset
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
    parameter WIDTH = 27,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    // clock and reset
    input  wire             clk_sys,
    input  wire             rst_n,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            do_wr;
    wire            do_rd;

    // flags from the count, so full and empty are exact
    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign do_wr     = in_valid & in_ready;
    assign do_rd     = out_valid & out_ready;

    // storage has no reset, only pointers and count do
    always @(posedge clk_sys) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers wrap, depth is a power of two
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_wr & ~do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd & ~do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** logic/video_link_tx_control.v ***
// video link transmitter control: pixel capture, window generator,
// blanking control encoding and the serial configuration slave
// assumes clk_sys is the pixel clock; all pins are asynchronous to it
`timescale 1ns/1ps
`default_nettype none
`include "video_link_tx_defs.vh"
module video_link_tx_control #(
    parameter [6:0] DEV_ADDR = `BUS_DEV_ADDR,
    parameter       FIFO_DEPTH = 4,
    parameter       FIFO_AW    = 2
) (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rst_n,
    // parallel pixel bus from the graphics controller
    input  wire [23:0] pixel_data,
    input  wire        line_sync,
    input  wire        frame_sync,
    input  wire        pixel_active_window,
    output reg         video_ready,
    // strap and control pins
    input  wire        serial_config_select,
    input  wire        deskew_enable,
    input  wire [1:0]  user_control_pins,
    // receiver presence
    input  wire        receiver_detect,
    output reg         receiver_sense_out,
    // serial configuration bus, open drain data
    input  wire        bus_scl,
    input  wire        bus_sda_in,
    output reg         bus_sda_out,
    output reg         bus_sda_oe_n,
    // encoded link words toward the serialiser
    output reg         link_valid,
    input  wire        link_ready,
    output reg         link_active,
    output reg  [23:0] link_pixel,
    output reg  [5:0]  link_ctrl
);
    localparam WORD_W = 27;
    // bus slave states
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_ADDR = 3'd1;
    localparam [2:0] ST_ACK  = 3'd2;
    localparam [2:0] ST_SUB  = 3'd3;
    localparam [2:0] ST_WR   = 3'd4;
    localparam [2:0] ST_READ = 3'd5;
    localparam [2:0] ST_RACK = 3'd6;

    // two-flop synchronisers for every pin except link_ready and rst_n
    reg [29:0] pin_s1;
    reg [29:0] pin_s2;
    reg [5:0]  ctl_s1;
    reg [5:0]  ctl_s2;
    reg        scl_d;
    reg        sda_d;
    // registers
    reg [7:0]  config_default_register;
    reg [3:1]  user_control_bits_register;
    reg [10:0] active_start_delay;
    reg [10:0] active_pixel_count;
    reg        win_gen_enable;
    reg        win_inactive_ref;
    // window generator
    reg        line_sync_d;
    reg [11:0] win_cnt;
    reg        win_run;
    // bus slave
    reg [2:0]  bus_state;
    reg [3:0]  bit_cnt;
    reg [7:0]  shreg;
    reg [7:0]  sub_addr;
    reg        rw_read;
    reg        got_sub;
    reg        master_nack;
    // fifo wiring
    wire                fifo_in_ready;
    wire                fifo_out_valid;
    wire [WORD_W-1:0]   fifo_out_data;
    wire                fifo_pop;
    wire [WORD_W-1:0]   fifo_in_data;
    // decoded pin levels
    wire [23:0] pix_s    = pin_s2[23:0];
    wire        hs_s     = pin_s2[24];
    wire        vs_s     = pin_s2[25];
    wire        de_s     = pin_s2[26];
    wire        bus_mode = ctl_s2[0];
    wire        dk_s     = ctl_s2[1];
    wire [1:0]  ucp_s    = ctl_s2[3:2];
    wire        rx_s     = ctl_s2[4];
    wire        scl_s    = pin_s2[27];
    wire        sda_s    = pin_s2[28];
    wire        scl_rise = scl_s & ~scl_d;
    wire        scl_fall = ~scl_s & scl_d;
    wire        bus_start = scl_s & scl_d & sda_d & ~sda_s;
    wire        bus_stop  = scl_s & scl_d & ~sda_d & sda_s;
    wire [11:0] win_end;
    wire        win_trigger;
    wire        gen_de;
    wire        de_used;
    reg  [2:1]  ctl_user;

    // register read decode, used for every read byte
    function [7:0] reg_read;
        input [7:0] sa;
        begin
            case (sa)
                `SA_CONFIG_DEFAULT: reg_read = config_default_register;
                `SA_USER_CONTROL:   reg_read = {4'h0, user_control_bits_register, 1'b0}; // [RQ8]
                `SA_STATUS:         reg_read = {5'h00, ~fifo_in_ready, bus_mode, rx_s};
                `SA_DELAY_LO:       reg_read = active_start_delay[7:0];
                `SA_DELAY_HI:       reg_read = {1'b0, win_gen_enable, win_inactive_ref,
                                                2'h0, active_start_delay[10:8]};
                `SA_COUNT_LO:       reg_read = active_pixel_count[7:0];
                `SA_COUNT_HI:       reg_read = {5'h00, active_pixel_count[10:8]};
                default:            reg_read = 8'h00;
            endcase
        end
    endfunction

    // pins cross in through two flops; only stage two is read by logic
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 30'h38000000; // bus idles high, syncs and window low
            pin_s2 <= 30'h38000000;
            ctl_s1 <= 6'h00;
            ctl_s2 <= 6'h00;
        end else begin
            pin_s1 <= {1'b1, bus_sda_in, bus_scl, pixel_active_window,
                       frame_sync, line_sync, pixel_data};
            pin_s2 <= pin_s1;
            ctl_s1 <= {1'b0, receiver_detect, user_control_pins,
                       deskew_enable, serial_config_select};
            ctl_s2 <= ctl_s1;
        end
    end

    // delayed copies of stage two for edge detection
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            scl_d       <= 1'b1;
            sda_d       <= 1'b1;
            line_sync_d <= 1'b0;
        end else begin
            scl_d       <= scl_s;
            sda_d       <= sda_s;
            line_sync_d <= hs_s;
        end
    end

    // window counts from the chosen line sync edge; no clamp, the host keeps
    // delay plus count under the limit [RQ1]
    assign win_trigger = win_inactive_ref ? (line_sync_d & ~hs_s)   // [RQ2]
                                          : (hs_s & ~line_sync_d);
    assign win_end = {1'b0, active_start_delay} + {1'b0, active_pixel_count};
    assign gen_de  = win_run & (win_cnt >= {1'b0, active_start_delay}) & (win_cnt < win_end);
    assign de_used = win_gen_enable ? gen_de : de_s;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            win_cnt <= 12'h000;
            win_run <= 1'b0;
        end else if (win_trigger) begin
            win_cnt <= 12'h000;
            win_run <= 1'b1;
        end else if (win_run) begin
            if (win_cnt >= win_end) begin
                win_run <= 1'b0;
            end else begin
                win_cnt <= win_cnt + 12'h001;
            end
        end
    end

    // the pin source cannot stall, so a full fifo drops samples; ready shows it
    assign fifo_in_data = {de_used, vs_s, hs_s, pix_s};

    sample_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (1'b1),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    // user bits: register in bus mode, else pins unless deskew is on,
    // when the pins carry skew, not control
    always @* begin
        if (bus_mode) begin
            ctl_user = user_control_bits_register[2:1];               // [RQ11]
        end else if (!dk_s) begin
            ctl_user = ucp_s;                                         // [RQ9]
        end else begin
            ctl_user = 2'b00;
        end
    end

    // output stage pops when empty or when the word is taken
    assign fifo_pop = fifo_out_valid & (~link_valid | link_ready);

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            link_valid  <= 1'b0;
            link_active <= 1'b0;
            link_pixel  <= 24'h000000;
            link_ctrl   <= 6'h00;
        end else if (fifo_pop) begin
            link_valid  <= 1'b1;
            link_active <= fifo_out_data[26];
            if (fifo_out_data[26]) begin
                link_pixel <= fifo_out_data[23:0];
                link_ctrl  <= 6'h00;
            end else begin
                link_pixel <= 24'h000000;
                // ch2 {top bit, bit2}, ch1 {bit1, 0}, ch0 {frame, line} [RQ10]
                // top bit forced low whatever pin or register holds [RQ6] [RQ7]
                link_ctrl  <= {1'b0, ctl_user[2], ctl_user[1], 1'b0,
                               fifo_out_data[25], fifo_out_data[24]};
            end
        end else if (link_ready) begin
            link_valid <= 1'b0;
        end
    end

    // status outputs; bus mode shows presence only in the status reg
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            video_ready        <= 1'b0;
            receiver_sense_out <= 1'b0;
        end else begin
            video_ready        <= fifo_in_ready;
            receiver_sense_out <= ~bus_mode & rx_s;                   // [RQ3]
        end
    end

    // serial configuration slave, 8-bit locations by sub-address [RQ12]
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bus_state    <= ST_IDLE;
            bit_cnt      <= 4'h0;
            shreg        <= 8'h00;
            sub_addr     <= 8'h00;
            rw_read      <= 1'b0;
            got_sub      <= 1'b0;
            master_nack  <= 1'b1;
            bus_sda_out  <= 1'b0;
            bus_sda_oe_n <= 1'b1;
            config_default_register    <= `RST_CONFIG_DEFAULT;       // [RQ5]
            user_control_bits_register <= `RST_USER_CONTROL;
            active_start_delay <= 11'h000;
            active_pixel_count <= 11'h000;
            win_gen_enable     <= 1'b0;
            win_inactive_ref   <= 1'b0;
        end else if (bus_start) begin
            bus_state    <= ST_ADDR;
            bit_cnt      <= 4'h0;
            got_sub      <= 1'b0;
            bus_sda_oe_n <= 1'b1;
        end else if (bus_stop) begin
            bus_state    <= ST_IDLE;
            bus_sda_oe_n <= 1'b1;
        end else begin
            case (bus_state)
                ST_ADDR, ST_SUB, ST_WR: begin
                    if (scl_rise) begin
                        shreg   <= {shreg[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == 4'h8) begin
                        bit_cnt <= 4'h0;
                        if (bus_state == ST_ADDR) begin
                            if (shreg[7:1] == DEV_ADDR) begin
                                rw_read      <= shreg[0];
                                bus_sda_oe_n <= 1'b0;
                                bus_state    <= ST_ACK;
                            end else begin
                                bus_state <= ST_IDLE;
                            end
                        end else if (bus_state == ST_SUB) begin
                            sub_addr     <= shreg;
                            got_sub      <= 1'b1;
                            bus_sda_oe_n <= 1'b0;
                            bus_state    <= ST_ACK;
                        end else begin
                            // status location drops writes [RQ4]
                            case (sub_addr)
                                `SA_CONFIG_DEFAULT: config_default_register <= shreg;
                                `SA_USER_CONTROL:   user_control_bits_register <= shreg[3:1];
                                `SA_DELAY_LO:       active_start_delay[7:0] <= shreg;
                                `SA_DELAY_HI: begin
                                    active_start_delay[10:8] <= shreg[2:0];
                                    win_gen_enable   <= shreg[`DHI_GEN_ENABLE];
                                    win_inactive_ref <= shreg[`DHI_INACTIVE_REF];
                                end
                                `SA_COUNT_LO:       active_pixel_count[7:0] <= shreg;
                                `SA_COUNT_HI:       active_pixel_count[10:8] <= shreg[2:0];
                                default: begin
                                end
                            endcase
                            sub_addr     <= sub_addr + 8'h01;
                            bus_sda_oe_n <= 1'b0;
                            bus_state    <= ST_ACK;
                        end
                    end
                end
                ST_ACK: begin
                    // acknowledge held for one scl pulse, released on its fall
                    if (scl_fall) begin
                        if (rw_read) begin
                            shreg        <= reg_read(sub_addr);
                            bus_sda_oe_n <= reg_read(sub_addr) > 8'h7f;
                            sub_addr     <= sub_addr + 8'h01;
                            bus_state    <= ST_READ;
                        end else begin
                            bus_sda_oe_n <= 1'b1;
                            bus_state    <= got_sub ? ST_WR : ST_SUB;
                        end
                    end
                end
                ST_READ: begin
                    if (scl_fall) begin
                        if (bit_cnt == 4'h7) begin
                            bit_cnt      <= 4'h0;
                            bus_sda_oe_n <= 1'b1;
                            bus_state    <= ST_RACK;
                        end else begin
                            shreg        <= {shreg[6:0], 1'b0};
                            bus_sda_oe_n <= shreg[6];
                            bit_cnt      <= bit_cnt + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        master_nack <= sda_s;
                    end else if (scl_fall) begin
                        if (master_nack) begin
                            bus_state <= ST_IDLE;
                        end else begin
                            shreg        <= reg_read(sub_addr);
                            bus_sda_oe_n <= reg_read(sub_addr) > 8'h7f;
                            sub_addr     <= sub_addr + 8'h01;
                            bus_state    <= ST_READ;
                        end
                    end
                end
                default: begin
                    bus_sda_oe_n <= 1'b1;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// *** verif/vltc_checker.sv ***
// port assertions for the video link transmitter control block
// assumes it is bound to video_link_tx_control, one clock domain
`timescale 1ns/1ps
`default_nettype none
module vltc_checker (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_n,
    // strap, control and presence pins
    input wire logic        serial_config_select,
    input wire logic        deskew_enable,
    input wire logic [1:0]  user_control_pins,
    input wire logic        receiver_detect,
    input wire logic        receiver_sense_out,
    // serial configuration bus
    input wire logic        bus_scl,
    input wire logic        bus_sda_out,
    input wire logic        bus_sda_oe_n,
    // link words
    input wire logic        link_valid,
    input wire logic        link_ready,
    input wire logic        link_active,
    input wire logic [23:0] link_pixel,
    input wire logic [5:0]  link_ctrl
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // a blanking word on the link
    wire blank_word = link_valid && !link_active;
    // five cycles cover two sync flops and the output flop
    a_sense_high: assert property ((!serial_config_select && receiver_detect)[*5] |-> receiver_sense_out)
        else $error("sense low with receiver present");
    a_sense_low: assert property ((!serial_config_select && !receiver_detect)[*5] |-> !receiver_sense_out)
        else $error("sense high with no receiver");
    a_sense_bus: assert property (serial_config_select[*5] |-> !receiver_sense_out)
        else $error("sense high in bus mode");
    a_top_ctrl_zero: assert property (link_valid |-> !link_ctrl[5])
        else $error("top control bit sent as one");
    a_active_clean: assert property (link_valid && link_active |-> link_ctrl == 6'h00)
        else $error("control bits during active word");
    a_blank_pixel: assert property (blank_word |-> link_pixel == 24'h000000)
        else $error("pixel leaks into blanking");
    a_word_stands: assert property (link_valid && !link_ready |=> link_valid && $stable(link_pixel)
        && $stable(link_ctrl) && $stable(link_active))
        else $error("stalled word changed");
    a_pin_user: assert property ((!serial_config_select && !deskew_enable && link_ready
        && $stable(user_control_pins))[*8] ##0 blank_word |-> link_ctrl[4:3] == user_control_pins)
        else $error("user pins not on link");
    a_deskew_quiet: assert property ((!serial_config_select && deskew_enable && link_ready)[*8]
        ##0 blank_word |-> link_ctrl[4:3] == 2'b00)
        else $error("user bits sent in deskew mode");
    a_ack_scl_low: assert property ($fell(bus_sda_oe_n) |-> !bus_scl && !bus_sda_out)
        else $error("data pulled while clock high");
    a_ack_hold: assert property ($fell(bus_sda_oe_n) |-> (!bus_sda_oe_n)[*4])
        else $error("data pull too short");
endmodule
`default_nettype wire

// *** verif/gfx_source.sv ***
// graphics controller model driving the parallel pixel pins
// pins move on the falling edge, driven by send_line
`timescale 1ns/1ps
`default_nettype none
module gfx_source (
    // clock
    input  wire logic        clk_sys,
    // parallel pixel bus
    output var  logic [23:0] pixel_data,
    output var  logic        line_sync,
    output var  logic        frame_sync,
    output var  logic        pixel_active_window
);
    initial {pixel_data, line_sync, frame_sync, pixel_active_window} = 27'h0000000;
    // sync pulse, blanking, n pixels from one; junk outside the window tests masking
    task send_line(input int n, input logic fs);
        for (int i = 0; i < n + 8; i++) begin
            @(negedge clk_sys);
            line_sync = (i < 2);
            frame_sync = fs && (i < 2);
            pixel_active_window = (i >= 6) && (i < n + 6);
            pixel_data = pixel_active_window ? 24'(i - 5) : ~pixel_data;
        end
    endtask
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking bench for the video link transmitter control block
// assumes the checker and graphics model compile first
`timescale 1ns/1ps
`default_nettype none
`include "video_link_tx_defs.vh"
module tb_top;
    logic        clk_sys, rst_n, scs, dsk, rx, scl, sda, lrdy;
    logic [1:0]  ucp;
    logic [23:0] last_pix;
    logic [5:0]  blk_ctl;
    logic        ord_bad, saw_full, saw_sync;
    int          cyc = 0, n_mismatch = 0, checks_done = 0, n_act = 0;
    wire  [23:0] pd, lpix;
    wire  [5:0]  lctl;
    wire         ls, fs, pw, vrdy, rso, sdo, sdoe, lval, lact;
    // pull-up data wire: low if either side pulls
    wire         sda_w = sda & (sdoe | sdo);
    gfx_source gfx_source_i (.clk_sys(clk_sys), .pixel_data(pd), .line_sync(ls),
        .frame_sync(fs), .pixel_active_window(pw));
    video_link_tx_control video_link_tx_control_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .pixel_data(pd), .line_sync(ls), .frame_sync(fs), .pixel_active_window(pw),
        .video_ready(vrdy), .serial_config_select(scs), .deskew_enable(dsk),
        .user_control_pins(ucp), .receiver_detect(rx), .receiver_sense_out(rso),
        .bus_scl(scl), .bus_sda_in(sda_w), .bus_sda_out(sdo), .bus_sda_oe_n(sdoe),
        .link_valid(lval), .link_ready(lrdy), .link_active(lact), .link_pixel(lpix),
        .link_ctrl(lctl));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // word sink bookkeeping and hang guard
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (!vrdy && rst_n) saw_full <= 1'b1;
        if (lval && lrdy && lact) begin
            n_act <= n_act + 1;
            if (lpix <= last_pix) ord_bad <= 1'b1;
            last_pix <= lpix;
        end
        if (lval && lrdy && !lact) blk_ctl <= lctl;
        if (lval && !lact && lctl[1:0] == 2'b11) saw_sync <= 1'b1;
        if (cyc == 40000) begin
            n_mismatch++;
            report_and_stop;
        end
    end
    task w(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task chk(input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // bus bit: eight cycles low, eight high, wire read mid-high
    task bit_w(input logic b, output logic r);
        sda = b;
        w(4);
        scl = 1'b1;
        w(4);
        r = sda_w;
        w(4);
        scl = 1'b0;
        w(4);
    endtask
    task bstart;
        sda = 1'b1;
        w(4);
        scl = 1'b1;
        w(8);
        sda = 1'b0;
        w(8);
        scl = 1'b0;
        w(4);
    endtask
    task bstop;
        sda = 1'b0;
        w(4);
        scl = 1'b1;
        w(8);
        sda = 1'b1;
        w(8);
    endtask
    task bbyte(input logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--) bit_w(d[i], a);
        bit_w(1'b1, a);
        chk(a, 1'b0);
    endtask
    task reg_wr(input logic [7:0] sa, input logic [7:0] d);
        bstart;
        bbyte({`BUS_DEV_ADDR, 1'b0});
        bbyte(sa);
        bbyte(d);
        bstop;
    endtask
    task reg_rd(input logic [7:0] sa, output logic [7:0] d);
        logic a;
        bstart;
        bbyte({`BUS_DEV_ADDR, 1'b0});
        bbyte(sa);
        bstart;
        bbyte({`BUS_DEV_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--) bit_w(1'b1, d[i]);
        bit_w(1'b1, a);
        bstop;
    endtask
    task t_regs;
        logic [7:0] v, s;
        reg_rd(`SA_CONFIG_DEFAULT, v);
        chk(v, 8'hbe);
        reg_rd(`SA_USER_CONTROL, v);
        chk(v, 8'h00);
        reg_wr(`SA_USER_CONTROL, 8'hff);
        reg_rd(`SA_USER_CONTROL, v);
        chk(v, 8'h0e);
        reg_rd(`SA_STATUS, s);
        chk(s, 8'h02);
        reg_wr(`SA_STATUS, ~s);
        reg_rd(`SA_STATUS, v);
        chk(v, s);
        reg_rd(8'h60, v);
        chk(v, 8'h00);
        w(10);
        chk(blk_ctl, 6'b011000);
        reg_wr(`SA_USER_CONTROL, 8'h08);
        w(10);
        chk(blk_ctl, 6'b000000);
        $display("done registers and control bits");
    endtask
    // generated window: rising ref, falling ref, largest legal sum
    task t_gen;
        reg_wr(`SA_COUNT_LO, 8'h05);
        reg_wr(`SA_COUNT_HI, 8'h00);
        for (int k = 0; k < 3; k++) begin
            reg_wr(`SA_DELAY_LO, k == 2 ? 8'hf9 : 8'h03);
            reg_wr(`SA_DELAY_HI, k == 0 ? 8'h40 : (k == 1 ? 8'h60 : 8'h47));
            n_act = 0;
            gfx_source_i.send_line(0, 1'b0);
            w(2100);
            chk(n_act, 5);
        end
        reg_wr(`SA_DELAY_HI, 8'h00);
        $display("done window generator");
    endtask
    task t_pins;
        scs = 1'b0;
        ucp = 2'b01;
        n_act = 0;
        saw_sync = 1'b0;
        gfx_source_i.send_line(6, 1'b1);
        w(10);
        chk(n_act, 6);
        chk(saw_sync, 1'b1);
        chk(blk_ctl, 6'b001000);
        dsk = 1'b1;
        w(12);
        chk(blk_ctl[4:3], 2'b00);
        rx = 1'b1;
        w(6);
        chk(rso, 1'b1);
        rx = 1'b0;
        w(6);
        chk(rso, 1'b0);
        $display("done pin mode");
    endtask
    // link stalls mid-line: buffer fills, drops, then drains in order
    task t_fifo;
        saw_full = 1'b0;
        ord_bad = 1'b0;
        last_pix = 24'h000000;
        n_act = 0;
        fork
            gfx_source_i.send_line(16, 1'b0);
            begin
                w(10);
                lrdy = 1'b0;
                w(10);
                chk(lval, 1'b1);
                lrdy = 1'b1;
            end
        join
        w(10);
        chk(saw_full, 1'b1);
        chk(ord_bad, 1'b0);
        chk(n_act > 3 && n_act < 16, 1'b1);
        $display("done buffer stall");
    endtask
    initial begin
        rst_n = 1'b0;
        scs = 1'b1;
        dsk = 1'b0;
        ucp = 2'b00;
        rx = 1'b0;
        scl = 1'b1;
        sda = 1'b1;
        lrdy = 1'b1;
        w(8);
        rst_n = 1'b1;
        w(4);
        t_regs;
        t_gen;
        t_pins;
        t_fifo;
        report_and_stop;
    end
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
endmodule
bind video_link_tx_control vltc_checker vltc_checker_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .serial_config_select(serial_config_select), .deskew_enable(deskew_enable),
    .user_control_pins(user_control_pins), .receiver_detect(receiver_detect),
    .receiver_sense_out(receiver_sense_out), .bus_scl(bus_scl), .bus_sda_out(bus_sda_out),
    .bus_sda_oe_n(bus_sda_oe_n), .link_valid(link_valid), .link_ready(link_ready),
    .link_active(link_active), .link_pixel(link_pixel), .link_ctrl(link_ctrl));
`default_nettype wire
